/* File: hw/hsq_regs.svh */
// Functional notes
// RL1: 28 off: rev rise, fwd fall, rev rise
// RL2: 28 on: fwd slow fall, rev slow rise
// RL3: 28 limit: fwd fast fall, rev slow rise
// RL4: 29 off: rev fast fall, fwd slow rise
// RL5: 29 on: same as inactive case
// RL6: 29 limit: fwd rise, rev fall, fwd rise
// RL7: 30 off: rev fall, fwd rise, rev fall
// RL8: 30 on: same as inactive case
// RL9: 30 limit: fwd fast rise, rev slow fall
// RL10: Methods 31 and 32 never start motion
// RL11: 33: reverse, finish at first index pulse
// RL12: 34: forward, finish at first index pulse
// RL13: Controller selects method before starting homing
// RL14: Configurable speeds; reversals decelerate to zero first
// RL15: Final edge halts motion and signals complete
`ifndef HSQ_REGS_SVH
`define HSQ_REGS_SVH
// =====================================================================
// Method codes
// =====================================================================
`define HSQ_METHOD_28 8'h1C
`define HSQ_METHOD_29 8'h1D
`define HSQ_METHOD_30 8'h1E
`define HSQ_METHOD_31 8'h1F
`define HSQ_METHOD_32 8'h20
`define HSQ_METHOD_33 8'h21
`define HSQ_METHOD_34 8'h22
// =====================================================================
// Branch codes and timing
// =====================================================================
`define HSQ_BR_OFF   2'h0
`define HSQ_BR_ON    2'h1
`define HSQ_BR_LIMIT 2'h2
// Ramp update interval in ns and its count of 10 ns clock cycles.
`define HSQ_RAMP_TICK_NS  1000
`define HSQ_CLK_PERIOD_NS 10
`define HSQ_RAMP_TICK_CYC (`HSQ_RAMP_TICK_NS / `HSQ_CLK_PERIOD_NS)
`define HSQ_RAMP_STEP     16
`endif

/* File: hw/hsq_pkg.sv */
// =====================================================================
// Types shared by the homing sequencer
// =====================================================================
package hsq_pkg;
   // Sequencer states.
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DECEL} hsq_state_e;
   // What a search step waits for.
   typedef enum logic [1:0] {EV_RISE, EV_FALL, EV_INDEX} hsq_event_e;
   // One search step of a homing procedure.
   typedef struct packed {
      logic       valid;   // Step exists.
      logic       rev;     // Reverse direction.
      logic       fast;    // High speed.
      hsq_event_e kind;    // Event that ends the step.
      logic       last;    // Ending event finishes homing.
   } hsq_step_s;
endpackage : hsq_pkg

/* File: hw/hsq_ramp.sv */
`timescale 1ns/1ns
`include "hsq_regs.svh"
// =====================================================================
// Speed ramp: moves the speed toward a target once per tick
// =====================================================================
module hsq_ramp import hsq_pkg::*; #(
   parameter int SPD_W    = 16,
   parameter int STEP     = `HSQ_RAMP_STEP,
   parameter int TICK_CYC = `HSQ_RAMP_TICK_CYC
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst_n,
   input  wire logic [SPD_W-1:0] i_target,
   input  wire logic             i_halt,
   output logic      [SPD_W-1:0] o_speed,
   output logic                  o_at_zero
);
   // Elaboration check: the divider is 16 bits wide and the step must fit the speed.
   if (STEP < 1 || TICK_CYC < 1 || TICK_CYC > 65536 || SPD_W < 2 ||
       (SPD_W < 31 && STEP >= (2 ** SPD_W))) begin : g_bad_param
      $error("hsq_ramp: bad parameters.");
   end

   logic [15:0]      div_q, div_d;     // Tick divider.
   logic [SPD_W-1:0] spd_q, spd_d;     // Present speed.
   logic             tick;             // One-cycle ramp enable.
   localparam logic [SPD_W-1:0] STEP_W = SPD_W'(STEP);

   // Divider and ramp next values; a halt drops speed at once.
   always_comb begin
      tick  = (div_q == 16'(TICK_CYC - 1));
      div_d = tick ? 16'h0000 : div_q + 16'h0001;
      spd_d = spd_q;
      if (i_halt) begin
         spd_d = '0;
      end else if (tick) begin
         if (spd_q < i_target) begin
            spd_d = (i_target - spd_q > STEP_W) ? spd_q + STEP_W : i_target;
         end else if (spd_q > i_target) begin
            spd_d = (spd_q - i_target > STEP_W) ? spd_q - STEP_W : i_target;
         end
      end
   end

   // Registers only.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q <= 16'h0000;
         spd_q <= '0;
      end else begin
         div_q <= div_d;
         spd_q <= spd_d;
      end
   end

   assign o_speed   = spd_q;
   assign o_at_zero = (spd_q == '0);
endmodule : hsq_ramp

/* File: hw/hsq_top.sv */
`timescale 1ns/1ns
`include "hsq_regs.svh"
// =====================================================================
// Homing sequencer for methods 28 to 34
// =====================================================================
module hsq_top import hsq_pkg::*; #(
   parameter int SPD_W    = 16,
   parameter int STEP     = `HSQ_RAMP_STEP,
   parameter int TICK_CYC = `HSQ_RAMP_TICK_CYC
) (
   input  wire logic             I_SYS_CLK,
   input  wire logic             I_RESET_N,
   input  wire logic             I_START,
   input  wire logic [7:0]       I_METHOD,
   input  wire logic [SPD_W-1:0] I_HIGH_SPEED,
   input  wire logic [SPD_W-1:0] I_LOW_SPEED,
   input  wire logic             I_HOME_SW,
   input  wire logic             I_REV_LIMIT,
   input  wire logic             I_INDEX,
   output logic      [SPD_W-1:0] O_SPEED,
   output logic                  O_DIR_REV,
   output logic                  O_BUSY,
   output logic                  O_DONE,
   output logic                  O_ERROR
);
   // =====================================================================
   // Reset release and pin synchronisers
   // =====================================================================
   logic       rst_m, rst_n;           // Reset release pair.
   logic [2:0] home_p, idx_p;          // Pin pipelines; bit 0 is first stage.
   logic [1:0] lim_p;                  // Limit pipeline; only its level is used.

   // Reset is asserted at once and released through two flops.
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   // Pins pass two flops; the third stage only feeds edge detection.
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         home_p <= 3'h0;
         lim_p  <= 2'h0;
         idx_p  <= 3'h0;
      end else begin
         home_p <= {home_p[1:0], I_HOME_SW};
         lim_p  <= {lim_p[0], I_REV_LIMIT};
         idx_p  <= {idx_p[1:0], I_INDEX};
      end
   end

   logic home_s, home_rise, home_fall, idx_rise, lim_s;
   assign home_s    = home_p[1];
   assign home_rise = home_p[1] & ~home_p[2];
   assign home_fall = ~home_p[1] & home_p[2];
   assign idx_rise  = idx_p[1] & ~idx_p[2];
   assign lim_s     = lim_p[1];

   // =====================================================================
   // Step table
   // =====================================================================
   function automatic hsq_step_s mk(input logic r, input logic f, input hsq_event_e k,
                                    input logic l);
      mk = '{valid: 1'b1, rev: r, fast: f, kind: k, last: l};
   endfunction : mk

   // Returns one search step of a method, branch and step index.
   function automatic hsq_step_s get_step(input logic [7:0] m, input logic [1:0] b,
                                          input logic [1:0] i);
      hsq_step_s s;
      s = '0;
      case (m)
         `HSQ_METHOD_28: begin
            if (b == `HSQ_BR_OFF) begin
               case (i)   // RL1
                  2'd0:    s = mk(1'b1, 1'b1, EV_RISE, 1'b0);
                  2'd1:    s = mk(1'b0, 1'b0, EV_FALL, 1'b0);
                  2'd2:    s = mk(1'b1, 1'b0, EV_RISE, 1'b1);
                  default: s = '0;
               endcase
            end else if (b == `HSQ_BR_ON) begin
               case (i)   // RL2
                  2'd0:    s = mk(1'b0, 1'b0, EV_FALL, 1'b0);
                  2'd1:    s = mk(1'b1, 1'b0, EV_RISE, 1'b1);
                  default: s = '0;
               endcase
            end else begin
               case (i)   // RL3
                  2'd0:    s = mk(1'b0, 1'b1, EV_FALL, 1'b0);
                  2'd1:    s = mk(1'b1, 1'b0, EV_RISE, 1'b1);
                  default: s = '0;
               endcase
            end
         end
         `HSQ_METHOD_29: begin
            if (b != `HSQ_BR_LIMIT) begin
               case (i)   // RL4 RL5
                  2'd0:    s = mk(1'b1, 1'b1, EV_FALL, 1'b0);
                  2'd1:    s = mk(1'b0, 1'b0, EV_RISE, 1'b1);
                  default: s = '0;
               endcase
            end else begin
               case (i)   // RL6
                  2'd0:    s = mk(1'b0, 1'b1, EV_RISE, 1'b0);
                  2'd1:    s = mk(1'b1, 1'b0, EV_FALL, 1'b0);
                  2'd2:    s = mk(1'b0, 1'b0, EV_RISE, 1'b1);
                  default: s = '0;
               endcase
            end
         end
         `HSQ_METHOD_30: begin
            if (b != `HSQ_BR_LIMIT) begin
               case (i)   // RL7 RL8
                  2'd0:    s = mk(1'b1, 1'b1, EV_FALL, 1'b0);
                  2'd1:    s = mk(1'b0, 1'b0, EV_RISE, 1'b0);
                  2'd2:    s = mk(1'b1, 1'b0, EV_FALL, 1'b1);
                  default: s = '0;
               endcase
            end else begin
               case (i)   // RL9
                  2'd0:    s = mk(1'b0, 1'b1, EV_RISE, 1'b0);
                  2'd1:    s = mk(1'b1, 1'b0, EV_FALL, 1'b1);
                  default: s = '0;
               endcase
            end
         end
         `HSQ_METHOD_33: s = (i == 2'd0) ? mk(1'b1, 1'b0, EV_INDEX, 1'b1) : '0; // RL11
         `HSQ_METHOD_34: s = (i == 2'd0) ? mk(1'b0, 1'b0, EV_INDEX, 1'b1) : '0; // RL12
         default:        s = '0;   // Reserved and unknown codes have no steps.
      endcase
      get_step = s;
   endfunction : get_step

   // =====================================================================
   // Sequencer state
   // =====================================================================
   hsq_state_e       state_q, state_d;     // Sequencer state.
   logic [7:0]       method_q, method_d;   // Method latched at start.
   logic [1:0]       br_q, br_d;           // Branch of the procedure.
   logic [1:0]       idx_q, idx_d;         // Step index.
   logic             dir_q, dir_d;         // Direction, reverse when high.
   logic             done_q, done_d;       // Homing complete.
   logic             err_q, err_d;         // Start refused or limit hit.
   logic             halt;                 // Drops speed to zero at once.
   logic [SPD_W-1:0] target;               // Ramp target speed.
   logic             at_zero;              // Ramp at standstill.
   logic             hit;                  // Ending event of the step seen.
   hsq_step_s        cur;                  // Present step.
   hsq_step_s        start_step;           // First step of the method offered at start.

   assign cur        = get_step(method_q, br_q, idx_q);
   assign start_step = get_step(I_METHOD, `HSQ_BR_OFF, 2'd0);

   // Step event detection; only counts once moving the step's way.
   always_comb begin
      case (cur.kind)
         EV_RISE:  hit = home_rise;
         EV_FALL:  hit = home_fall;
         EV_INDEX: hit = idx_rise;
         default:  hit = 1'b0;
      endcase
      hit = hit & (dir_q == cur.rev) & ~at_zero;
   end

   // Next state of the sequencer.
   always_comb begin
      state_d  = state_q;
      method_d = method_q;
      br_d     = br_q;
      idx_d    = idx_q;
      dir_d    = dir_q;
      done_d   = done_q;
      err_d    = err_q;
      halt     = 1'b0;
      target   = '0;
      case (state_q)
         ST_IDLE: begin
            if (I_START) begin
               done_d   = 1'b0;
               method_d = I_METHOD;
               br_d     = home_s ? `HSQ_BR_ON : `HSQ_BR_OFF;
               idx_d    = 2'd0;
               // Reserved and unknown methods are refused without motion.
               if (start_step.valid) begin   // RL10
                  state_d = ST_RUN;
                  err_d   = 1'b0;
               end else begin
                  err_d = 1'b1;
               end
            end
         end
         ST_RUN: begin
            // Direction may only change from standstill.
            if (at_zero) begin
               dir_d = cur.rev;   // RL14
            end
            if (dir_q == cur.rev) begin
               target = cur.fast ? I_HIGH_SPEED : I_LOW_SPEED;   // RL14
            end
            if (hit && cur.last) begin
               halt    = 1'b1;   // RL15
               done_d  = 1'b1;   // RL15
               state_d = ST_IDLE;
            end else if (hit) begin
               idx_d   = idx_q + 2'd1;
               state_d = ST_DECEL;   // RL14
            end else if (lim_s && cur.rev && !at_zero) begin
               if (idx_q == 2'd0 && cur.fast && br_q != `HSQ_BR_LIMIT) begin
                  br_d    = `HSQ_BR_LIMIT;   // RL3 RL6 RL9
                  state_d = ST_DECEL;
               end else begin
                  halt    = 1'b1;
                  err_d   = 1'b1;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_DECEL: begin
            // Every step change passes through standstill.
            if (at_zero) begin
               state_d = ST_RUN;   // RL14
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // Registers only.
   always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= ST_IDLE;
         method_q <= 8'h00;
         br_q     <= 2'h0;
         idx_q    <= 2'h0;
         dir_q    <= 1'b0;
         done_q   <= 1'b0;
         err_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         method_q <= method_d;
         br_q     <= br_d;
         idx_q    <= idx_d;
         dir_q    <= dir_d;
         done_q   <= done_d;
         err_q    <= err_d;
      end
   end

   // =====================================================================
   // Speed ramp and outputs
   // =====================================================================
   hsq_ramp #(.SPD_W(SPD_W), .STEP(STEP), .TICK_CYC(TICK_CYC)) u_ramp (
      .i_clk     (I_SYS_CLK),
      .i_rst_n   (rst_n),
      .i_target  (target),
      .i_halt    (halt),
      .o_speed   (O_SPEED),
      .o_at_zero (at_zero)
   );

   assign O_DIR_REV = dir_q;
   assign O_BUSY    = (state_q != ST_IDLE);
   assign O_DONE    = done_q;
   assign O_ERROR   = err_q;

   // =====================================================================
   // Checks
   // =====================================================================
   chk_reserved_refused: // RL10
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (state_q == ST_IDLE && I_START &&
       (I_METHOD == `HSQ_METHOD_31 || I_METHOD == `HSQ_METHOD_32))
      |=> (state_q == ST_IDLE && err_q) ##1 O_SPEED == '0)
      else $error("Reserved method started motion.");

   chk_done_stopped: // RL15
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      $rose(done_q) |-> O_SPEED == '0 && state_q == ST_IDLE)
      else $error("Done raised while moving.");

   chk_dir_at_rest: // RL14
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (dir_q != $past(dir_q)) |-> $past(O_SPEED) == '0)
      else $error("Direction changed while moving.");

   chk_m28_off_start: // RL1
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (state_q == ST_IDLE && I_START && I_METHOD == `HSQ_METHOD_28 && !home_s)
      |=> state_q == ST_RUN && cur.rev && cur.fast && cur.kind == EV_RISE ##1 dir_q)
      else $error("Method 28 inactive start wrong.");

   chk_m28_on_start: // RL2
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (state_q == ST_IDLE && I_START && I_METHOD == `HSQ_METHOD_28 && home_s)
      |=> !cur.rev && !cur.fast && cur.kind == EV_FALL ##1 !dir_q)
      else $error("Method 28 active start wrong.");

   chk_limit_turn: // RL3
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (state_q == ST_RUN && method_q == `HSQ_METHOD_28 && br_q == `HSQ_BR_OFF &&
       idx_q == 2'd0 && lim_s && !hit && !at_zero && dir_q)
      |=> state_q == ST_DECEL && br_q == `HSQ_BR_LIMIT && !cur.rev && cur.fast)
      else $error("Limit did not turn the search.");

   chk_m29_any_level: // RL4
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (state_q == ST_IDLE && I_START && I_METHOD == `HSQ_METHOD_29)
      |=> cur.rev && cur.fast && cur.kind == EV_FALL)
      else $error("Method 29 first search wrong.");

   chk_index_finish: // RL11
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (state_q == ST_RUN && method_q == `HSQ_METHOD_33 && idx_rise && dir_q && !at_zero)
      |=> done_q && O_SPEED == '0 && !O_BUSY)
      else $error("Index pulse did not finish homing.");

   chk_m34_forward: // RL12
   assert property (@(posedge I_SYS_CLK) disable iff (!rst_n)
      (state_q == ST_RUN && method_q == `HSQ_METHOD_34)
      |-> !cur.rev && cur.kind == EV_INDEX && (at_zero || !O_DIR_REV))
      else $error("Method 34 not forward index search.");
endmodule : hsq_top

/* File: bench/hsq_axis_model.sv */
`timescale 1ns/1ns
// =====================================================================
// Axis model: home cam, reverse limit and index marks along a travel
// =====================================================================
module hsq_axis_model #(
   parameter int HOME_LO = 1000,  // Lower end of the home cam.
   parameter int HOME_HI = 1400,  // Upper end of the home cam.
   parameter int LIM_POS = 40,    // Reverse limit is active at or below this.
   parameter int IDX_PER = 512    // Distance between encoder index marks.
) (
   input  wire logic               i_clk,
   input  wire logic               i_load,
   input  wire logic signed [31:0] i_load_pos,
   input  wire logic        [15:0] i_speed,
   input  wire logic               i_dir_rev,
   output logic signed      [31:0] o_pos,
   output logic                    o_home_sw,
   output logic                    o_rev_limit,
   output logic                    o_index
);
   // Position moves by the commanded speed every clock; a load places the axis.
   // The update lands just after the edge, as a real encoder count would.
   always_ff @(posedge i_clk) begin
      if (i_load) begin
         o_pos <= i_load_pos;
      end else if (i_dir_rev) begin
         o_pos <= o_pos - $signed({16'h0000, i_speed});
      end else begin
         o_pos <= o_pos + $signed({16'h0000, i_speed});
      end
   end
   // Levels follow position only, so every edge comes from real travel.
   // The index window is wider than the fastest step, so no mark is jumped.
   assign o_home_sw   = (o_pos >= HOME_LO) && (o_pos <= HOME_HI);
   assign o_rev_limit = (o_pos <= LIM_POS);
   assign o_index     = (o_pos >= 0) && ((o_pos % IDX_PER) < 16);
endmodule : hsq_axis_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ns
`include "hsq_regs.svh"
// =====================================================================
// Self-checking bench for the homing sequencer
// =====================================================================
module tb_top;
   localparam int HLO = 1000;   // Home cam lower end.
   localparam int HHI = 1400;   // Home cam upper end.
   localparam int TOL = 24;     // Overshoot allowed from sync and halt delay.
   localparam int TMO = 60000;  // Cycle ceiling for the whole run.
   // One expected outcome of a homing run.
   typedef struct {int pos; logic done; logic err; logic [15:0] max_spd;} hsq_note_s;
   logic               clk;
   logic               rst_n;
   logic               start    = 1'b0;
   logic               load     = 1'b1;
   logic               res_stb  = 1'b0;
   logic        [7:0]  method   = 8'h00;
   logic        [15:0] hi_spd   = 16'h0008;
   logic        [15:0] lo_spd   = 16'h0002;
   logic        [15:0] speed;
   logic        [15:0] max_spd  = 16'h0000;
   logic        [15:0] prev_spd = 16'h0000;
   logic signed [31:0] load_pos = 3000;
   logic signed [31:0] pos;
   logic               home_sw, rev_lim, index, dir_rev, busy, done, err;
   logic               prev_dir = 1'b0;
   int                 num_errors = 0;
   int                 samples_checked = 0;
   int                 cycles = 0;
   int                 test_no = 0;
   int                 seed = 58;
   hsq_note_s          notes[$];

   // =====================================================================
   // Design and axis model
   // =====================================================================
   // A one-cycle tick and a huge step make each ramp finish at once.
   hsq_top #(.SPD_W(16), .STEP(4096), .TICK_CYC(1)) u_hsq_top (
      .I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_START(start), .I_METHOD(method),
      .I_HIGH_SPEED(hi_spd), .I_LOW_SPEED(lo_spd), .I_HOME_SW(home_sw),
      .I_REV_LIMIT(rev_lim), .I_INDEX(index), .O_SPEED(speed), .O_DIR_REV(dir_rev),
      .O_BUSY(busy), .O_DONE(done), .O_ERROR(err));
   hsq_axis_model #(.HOME_LO(HLO), .HOME_HI(HHI)) u_hsq_axis_model (
      .i_clk(clk), .i_load(load), .i_load_pos(load_pos), .i_speed(speed),
      .i_dir_rev(dir_rev), .o_pos(pos), .o_home_sw(home_sw), .o_rev_limit(rev_lim),
      .o_index(index));

   // Free-running 100 MHz clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // =====================================================================
   // Reporting
   // =====================================================================
   // Counts and prints one mismatch.
   task automatic fail(input string msg);
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask : fail

   // Prints the counts and the verdict, then stops the run.
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test

   // =====================================================================
   // Driver
   // =====================================================================
   // Places the axis, notes the expectation, pulses start and waits for the end.
   // With poke set, a reserved start is thrown in mid-run and must be ignored.
   task automatic run(input logic [7:0] m, input int p, input int ep, input logic ed,
                      input logic ee, input logic [15:0] em, input bit poke);
      int        n;
      hsq_note_s nt;
      load     <= 1'b1;
      load_pos <= p;
      @(posedge clk);
      load <= 1'b0;
      repeat (4) @(posedge clk);
      nt = '{ep, ed, ee, em};
      notes.push_back(nt);
      start  <= 1'b1;
      method <= m;
      @(posedge clk);
      start  <= 1'b0;
      method <= 8'($random(seed));
      repeat (3) @(posedge clk);
      n = 0;
      while (busy === 1'b1 && n < 30000) begin
         start <= poke && (n == 50);
         if (poke && n == 50) begin
            method <= `HSQ_METHOD_32;
         end
         @(posedge clk);
         n++;
      end
      start   <= 1'b0;
      res_stb <= 1'b1;
      @(posedge clk);
      res_stb <= 1'b0;
      @(posedge clk);
   endtask : run

   // Reset, then every method and branch, refused codes and random index runs.
   initial begin
      int          p;
      int          ep;
      logic [7:0]  m;
      logic [15:0] ls;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      run(`HSQ_METHOD_28, 3000, HHI, 1'b1, 1'b0, hi_spd, 1'b0);
      run(`HSQ_METHOD_28, 1200, HHI, 1'b1, 1'b0, lo_spd, 1'b0);
      run(`HSQ_METHOD_28, 500, HHI, 1'b1, 1'b0, hi_spd, 1'b0);
      run(`HSQ_METHOD_29, 3000, HLO, 1'b1, 1'b0, hi_spd, 1'b0);
      run(`HSQ_METHOD_29, 1200, HLO, 1'b1, 1'b0, hi_spd, 1'b0);
      run(`HSQ_METHOD_29, 500, HLO, 1'b1, 1'b0, hi_spd, 1'b0);
      run(`HSQ_METHOD_30, 3000, HLO, 1'b1, 1'b0, hi_spd, 1'b1);
      run(`HSQ_METHOD_30, 1200, HLO, 1'b1, 1'b0, hi_spd, 1'b0);
      run(`HSQ_METHOD_30, 500, HLO, 1'b1, 1'b0, hi_spd, 1'b0);
      run(`HSQ_METHOD_31, 3000, 3000, 1'b0, 1'b1, 16'h0000, 1'b0);
      run(`HSQ_METHOD_32, 3000, 3000, 1'b0, 1'b1, 16'h0000, 1'b0);
      run(`HSQ_METHOD_33, 300, 40, 1'b0, 1'b1, lo_spd, 1'b0);
      for (int i = 0; i < 6; i++) begin
         ls = 16'h0001 + 16'($unsigned($random(seed)) % 3);
         lo_spd <= ls;
         p = 3100 + int'($unsigned($random(seed)) % 400);
         m = i[0] ? `HSQ_METHOD_34 : `HSQ_METHOD_33;
         ep = i[0] ? (p / 512 + 1) * 512 : (p / 512) * 512 + 15;
         run(m, p, ep, 1'b1, 1'b0, ls, 1'b0);
         m = 8'h23 + 8'($unsigned($random(seed)) % 221);
         run(m, p, p, 1'b0, 1'b1, 16'h0000, 1'b0);
      end
      end_of_test();
   end

   // =====================================================================
   // Monitor
   // =====================================================================
   // Tracks peak speed and turns, and compares each run's end with its note.
   always @(posedge clk) begin : mon
      hsq_note_s nt;
      cycles <= cycles + 1;
      if (start === 1'b1) begin
         max_spd <= 16'h0000;
      end else if (speed > max_spd) begin
         max_spd <= speed;
      end
      prev_dir <= dir_rev;
      prev_spd <= speed;
      if (dir_rev !== prev_dir) begin
         samples_checked++;
         if (prev_spd !== 16'h0000) fail("direction turned while moving");
      end
      if (res_stb === 1'b1) begin
         nt = notes.pop_front();
         samples_checked += 5;
         if (done !== nt.done) fail("done flag wrong");
         if (err !== nt.err) fail("error flag wrong");
         if (speed !== 16'h0000 || busy !== 1'b0) fail("axis not halted");
         if (max_spd !== nt.max_spd) fail("search speed wrong");
         if (pos - nt.pos > TOL || nt.pos - pos > TOL) fail("stop position wrong");
         $display("test %0d ended at position %0d", test_no, pos);
         test_no++;
      end
      if (cycles == TMO) begin
         fail("run did not finish");
         end_of_test();
      end
   end
endmodule : tb_top
